//--- shared/pin_mux_pkg.sv
// constants, register map and types for the strap and pin multiplexer
// assumes one processor clock and an active-low asynchronous master reset
//
// Summary of operation
// (RL1) strap pins are sampled only during reset, then act as flags
// (RL2) memory mode comes from the mode strap level taken at reset
// (RL3) memory mode never changes while running; only reset reselects it
// (RL4) strap low selects full memory mode with byte DMA and full bus
// (RL5) strap high selects host mode with host port and reduced bus
// (RL6) full mode drives a 14-bit address shared by all spaces
// (RL7) full mode uses 24-bit data; top 8 bits add byte addresses
// (RL8) host mode offers a 16-bit multiplexed address/data host port
// (RL9) host mode keeps only the lowest external address bit
// (RL10) host mode keeps only data lines 23 down to 8 externally
// (RL11) host drives select, latch, write and read to use the port
// (RL12) host mode drives an acknowledge telling the host it is served
// (RL13) outside logic decodes peripherals from address bit and selects
// (RL14) active-low space selects plus read and write enables are driven
// (RL15) shared interrupt two is edge or level sensitive, also flag 7
// (RL16) the two level interrupts on flags 5 and 6 are always level
// (RL17) the edge interrupt on flag 4 is always edge sensitive
// (RL18) bus request is answered by bus grant and grant hung outputs
// (RL19) three output-only flag pins are provided
// (RL20) serial port one pins become two interrupts, flag in, flag out
// (RL21) shared pins keep flag and interrupt; own flag output can interrupt
// (RL22) a software control setting picks serial or interrupt/flag use
// (RL23) bus setup is fixed at reset; serial pin use changes any time
// (RL24) strap values latch at reset release and hold until next reset
// (RL25) flag drivers on strap pins stay off while reset is asserted
package pin_mux_pkg;
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [3:0] REG_FLAG_DIR = 4'h0;
  localparam logic [3:0] REG_FLAG_OUT = 4'h1;
  localparam logic [3:0] REG_FLAG_IN = 4'h2;
  localparam logic [3:0] REG_SYS_CFG = 4'h3;
  localparam logic [3:0] REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] REG_MODE_STAT = 4'h5;
  localparam logic [7:0] FLAG_DIR_RST = 8'h00;
  localparam logic [7:0] FLAG_OUT_RST = 8'h00;
  localparam logic [2:0] OFLAG_RST = 3'h0;
  localparam logic [7:0] SYS_CFG_RST = 8'h30;
  localparam logic [5:0] IRQ_IDLE = 6'h3F;
  localparam int MODE_BIT = 2;
  localparam int CFG_IRQ_CFG_TWO_N_EDGE = 0;
  localparam int CFG_ALT0_EDGE = 1;
  localparam int CFG_ALT1_EDGE = 2;
  localparam int CFG_ALT_EN = 3;
  localparam int CFG_CMS_LSB = 4;
  localparam logic [1:0] SPACE_DATA = 2'h0;
  localparam logic [1:0] SPACE_PROG = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;
  localparam logic [1:0] SPACE_BYTE = 2'h3;
  typedef enum logic [1:0] {
    ST_OWN = 2'b01,
    ST_GRANT = 2'b10
  } bus_state_t;
endpackage

//--- core/boot_mode_strap_pin_mux.sv
// strap capture, flag pins, interrupt pin conditioning, memory bus pin mux,
// host port front end and bus request/grant of the processor
// assumes all pin inputs synchronous to i_sys_clk; pad logic joins oe/out/in
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
module boot_mode_strap_pin_mux (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  input wire logic [7:0] i_gp_flag,
  output logic [7:0] o_gp_flag,
  output logic [7:0] o_gp_flag_oe,
  output logic [2:0] o_output_only_flags,
  input wire logic [1:0] i_serial_alt_irqs_n,
  input wire logic i_serial_alt_flag_in,
  output logic o_serial_alt_flag_out,
  output logic o_serial_alt_en,
  output logic [5:0] o_irq_req,
  output logic o_host_mode,
  input wire logic i_mem_req,
  input wire logic i_mem_wr,
  input wire logic [1:0] i_mem_space,
  input wire logic [13:0] i_mem_addr,
  input wire logic [7:0] i_mem_byte_hi,
  input wire logic [23:0] i_mem_wdata,
  output logic [23:0] o_mem_rdata,
  output logic [13:0] o_ext_address_bus,
  input wire logic [23:0] i_ext_data_bus,
  output logic [23:0] o_ext_data_bus,
  output logic [23:0] o_ext_data_oe,
  output logic o_data_space_select_n,
  output logic o_program_space_select_n,
  output logic o_io_space_select_n,
  output logic o_byte_space_select_n,
  output logic o_combined_space_select_n,
  output logic o_mem_read_n,
  output logic o_mem_write_n,
  input wire logic i_bus_request_n,
  output logic o_bus_grant_n,
  output logic o_bus_grant_hung_n,
  input wire logic [15:0] i_host_port_addr_data,
  output logic [15:0] o_host_port_addr_data,
  output logic o_host_port_addr_data_oe,
  input wire logic i_host_port_select_n,
  input wire logic i_host_port_addr_latch,
  input wire logic i_host_port_write_n,
  input wire logic i_host_port_read_n,
  output logic o_host_port_ack_n,
  output logic [15:0] o_dma_addr,
  output logic [15:0] o_dma_wdata,
  output logic o_dma_wr,
  output logic o_dma_rd,
  input wire logic [15:0] i_dma_rdata
);

  function automatic logic [3:0] space_dec(input logic [1:0] space);
    space_dec = 4'h1 << space;
  endfunction

  // strap capture: tracks pins on every edge while reset holds; the last
  // sample is the edge that releases reset, before the strap driver lets go
  logic strap_taken;
  logic [2:0] strap;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1; // RL24
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      strap <= i_gp_flag[2:0]; // RL1 RL24
    end
  end
  wire host_mode = strap[pin_mux_pkg::MODE_BIT]; // RL2 RL3 RL4 RL5

  // software registers
  logic [7:0] flag_dir;
  logic [7:0] flag_out;
  logic [2:0] oflags;
  logic alt_fo;
  logic [7:0] sys_cfg;
  logic [5:0] edge_pend;
  logic [5:0] src_prev;
  wire wr_dir = i_reg_wr && (i_reg_addr == pin_mux_pkg::REG_FLAG_DIR);
  wire wr_out = i_reg_wr && (i_reg_addr == pin_mux_pkg::REG_FLAG_OUT);
  wire wr_cfg = i_reg_wr && (i_reg_addr == pin_mux_pkg::REG_SYS_CFG);
  wire wr_clr = i_reg_wr && (i_reg_addr == pin_mux_pkg::REG_IRQ_STAT);
  wire alt_en = sys_cfg[pin_mux_pkg::CFG_ALT_EN]; // RL22 RL23

  // pin level as seen by the core, including our own drive
  wire [7:0] pin_lvl = (o_gp_flag_oe & o_gp_flag) |
    (~o_gp_flag_oe & i_gp_flag); // RL21
  // active-low request sources: edge, lvl a, lvl b, irq_cfg_two_n, alt0, alt1
  wire [1:0] alt_src = alt_en ? i_serial_alt_irqs_n : 2'h3; // RL20
  wire [5:0] src = {alt_src, pin_lvl[7:4]};
  wire [5:0] edge_mode = {sys_cfg[pin_mux_pkg::CFG_ALT1_EDGE],
    sys_cfg[pin_mux_pkg::CFG_ALT0_EDGE],
    sys_cfg[pin_mux_pkg::CFG_IRQ_CFG_TWO_N_EDGE], 3'b001}; // RL15 RL16 RL17
  wire [5:0] pend_set = src_prev & ~src & edge_mode;
  wire [5:0] pend_clr = wr_clr ? i_reg_wdata[5:0] : 6'h00;
  // a new edge beats a clear in the same cycle
  wire [5:0] next_edge_pend = (edge_pend & ~pend_clr) | pend_set;
  wire [5:0] next_irq_req = (edge_mode & edge_pend) |
    (~edge_mode & ~src); // RL16

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_dir <= pin_mux_pkg::FLAG_DIR_RST;
      flag_out <= pin_mux_pkg::FLAG_OUT_RST;
      oflags <= pin_mux_pkg::OFLAG_RST;
      alt_fo <= 1'b0;
      sys_cfg <= pin_mux_pkg::SYS_CFG_RST;
      edge_pend <= 6'h00;
      src_prev <= pin_mux_pkg::IRQ_IDLE;
      o_irq_req <= 6'h00;
    end else begin
      if (wr_dir) begin
        flag_dir <= i_reg_wdata[7:0];
      end
      if (wr_out) begin
        flag_out <= i_reg_wdata[7:0];
        oflags <= i_reg_wdata[10:8]; // RL19
        alt_fo <= i_reg_wdata[11];
      end
      if (wr_cfg) begin
        sys_cfg <= i_reg_wdata[7:0]; // RL22 RL23
      end
      edge_pend <= next_edge_pend; // RL17
      src_prev <= src;
      o_irq_req <= next_irq_req; // RL15 RL21
    end
  end

  // flag pin drivers; strap pins stay undriven until the strap is frozen
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gp_flag <= 8'h00;
      o_gp_flag_oe <= 8'h00;
      o_output_only_flags <= pin_mux_pkg::OFLAG_RST;
      o_serial_alt_flag_out <= 1'b0;
      o_serial_alt_en <= 1'b0;
      o_host_mode <= 1'b0;
    end else begin
      o_gp_flag <= flag_out;
      o_gp_flag_oe <= strap_taken ? flag_dir : 8'h00; // RL25 RL1
      o_output_only_flags <= oflags; // RL19
      o_serial_alt_flag_out <= alt_en & alt_fo; // RL20
      o_serial_alt_en <= alt_en; // RL22
      o_host_mode <= strap_taken & host_mode; // RL3
    end
  end

  // bus request / grant
  pin_mux_pkg::bus_state_t bus_state;
  pin_mux_pkg::bus_state_t next_bus_state;
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      pin_mux_pkg::ST_OWN: begin
        if (!i_bus_request_n && !i_mem_req) begin
          next_bus_state = pin_mux_pkg::ST_GRANT; // RL18
        end
      end
      pin_mux_pkg::ST_GRANT: begin
        if (i_bus_request_n) begin
          next_bus_state = pin_mux_pkg::ST_OWN;
        end
      end
      default: next_bus_state = pin_mux_pkg::ST_OWN;
    endcase
  end
  wire granted = (bus_state == pin_mux_pkg::ST_GRANT);

  // memory bus pin mux
  wire drive = strap_taken && !granted && i_mem_req;
  wire [3:0] sel = drive ? space_dec(i_mem_space) : 4'h0; // RL14
  wire byte_acc = (i_mem_space == pin_mux_pkg::SPACE_BYTE);
  wire [3:0] cms_en = sys_cfg[pin_mux_pkg::CFG_CMS_LSB +: 4];
  wire [15:0] wr_lanes = (drive && i_mem_wr) ? 16'hFFFF : 16'h0000;
  wire [7:0] hi_lanes = (drive && byte_acc) ? 8'hFF : wr_lanes[7:0];
  wire [13:0] full_addr = i_mem_addr; // RL6
  wire [13:0] host_addr = {13'h0000, i_mem_addr[0]}; // RL9 RL13
  wire [23:0] full_data = byte_acc ?
    {i_mem_byte_hi, i_mem_wdata[15:0]} : i_mem_wdata; // RL7
  wire [23:0] host_data = {i_mem_wdata[15:0], 8'h00}; // RL10
  wire [23:0] full_oe = {hi_lanes, wr_lanes}; // RL7
  wire [23:0] host_oe = {wr_lanes, 8'h00}; // RL10
  wire [23:0] rdata_mux = host_mode ?
    {8'h00, i_ext_data_bus[23:8]} : i_ext_data_bus;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_state <= pin_mux_pkg::ST_OWN;
      o_bus_grant_n <= 1'b1;
      o_bus_grant_hung_n <= 1'b1;
    end else begin
      bus_state <= next_bus_state;
      o_bus_grant_n <= (next_bus_state != pin_mux_pkg::ST_GRANT); // RL18
      o_bus_grant_hung_n <= !(granted && i_mem_req); // RL18
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext_address_bus <= 14'h0000;
      o_ext_data_bus <= 24'h000000;
      o_ext_data_oe <= 24'h000000;
      o_data_space_select_n <= 1'b1;
      o_program_space_select_n <= 1'b1;
      o_io_space_select_n <= 1'b1;
      o_byte_space_select_n <= 1'b1;
      o_combined_space_select_n <= 1'b1;
      o_mem_read_n <= 1'b1;
      o_mem_write_n <= 1'b1;
      o_mem_rdata <= 24'h000000;
    end else begin
      o_ext_address_bus <= host_mode ? host_addr : full_addr; // RL6 RL9
      o_ext_data_bus <= host_mode ? host_data : full_data;
      o_ext_data_oe <= host_mode ? host_oe : full_oe; // RL7 RL10
      o_data_space_select_n <= !sel[pin_mux_pkg::SPACE_DATA]; // RL14
      o_program_space_select_n <= !sel[pin_mux_pkg::SPACE_PROG];
      o_io_space_select_n <= !sel[pin_mux_pkg::SPACE_IO];
      o_byte_space_select_n <= !sel[pin_mux_pkg::SPACE_BYTE];
      o_combined_space_select_n <= !(|(sel & cms_en)); // RL14
      o_mem_read_n <= !(drive && !i_mem_wr);
      o_mem_write_n <= !(drive && i_mem_wr);
      o_mem_rdata <= rdata_mux;
    end
  end

  // host port front end, live only in host mode
  logic hp_wr_prev;
  logic hp_rd_prev;
  wire hp_sel = strap_taken && host_mode && !i_host_port_select_n; // RL11
  wire hp_wr_fall = hp_sel && hp_wr_prev && !i_host_port_write_n;
  wire hp_rd_fall = hp_sel && hp_rd_prev && !i_host_port_read_n;
  wire hp_rd_rise = hp_sel && !hp_rd_prev && i_host_port_read_n;
  wire hp_busy = hp_sel && (!i_host_port_write_n || !i_host_port_read_n);
  wire [15:0] dma_inc = 16'(o_dma_addr + 16'h0001);
  wire [15:0] next_dma_addr = (hp_sel && i_host_port_addr_latch) ?
    i_host_port_addr_data : ((hp_wr_fall || hp_rd_rise) ?
    dma_inc : o_dma_addr); // RL8

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hp_wr_prev <= 1'b1;
      hp_rd_prev <= 1'b1;
      o_dma_addr <= 16'h0000;
      o_dma_wdata <= 16'h0000;
      o_dma_wr <= 1'b0;
      o_dma_rd <= 1'b0;
      o_host_port_addr_data <= 16'h0000;
      o_host_port_addr_data_oe <= 1'b0;
      o_host_port_ack_n <= 1'b1;
    end else begin
      hp_wr_prev <= i_host_port_write_n;
      hp_rd_prev <= i_host_port_read_n;
      o_dma_addr <= next_dma_addr; // RL8
      if (hp_wr_fall) begin
        o_dma_wdata <= i_host_port_addr_data;
      end
      o_dma_wr <= hp_wr_fall;
      o_dma_rd <= hp_rd_fall;
      o_host_port_addr_data <= i_dma_rdata;
      o_host_port_addr_data_oe <= hp_sel && !i_host_port_read_n; // RL8
      o_host_port_ack_n <= !hp_busy; // RL12
    end
  end

  // register read-back, valid only in the cycle after the read strobe
  wire [15:0] rd_mux =
    (i_reg_addr == pin_mux_pkg::REG_FLAG_DIR) ? {8'h00, flag_dir} :
    (i_reg_addr == pin_mux_pkg::REG_FLAG_OUT) ?
      {4'h0, alt_fo, oflags, flag_out} :
    (i_reg_addr == pin_mux_pkg::REG_FLAG_IN) ?
      {7'h00, i_serial_alt_flag_in, pin_lvl} :
    (i_reg_addr == pin_mux_pkg::REG_SYS_CFG) ? {8'h00, sys_cfg} :
    (i_reg_addr == pin_mux_pkg::REG_IRQ_STAT) ? {10'h000, o_irq_req} :
    (i_reg_addr == pin_mux_pkg::REG_MODE_STAT) ?
      {11'h000, granted, o_host_mode, strap} : 16'h0000;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= 16'h0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
    end
  end

  AST_STRAP_FROZEN: assert property (@(posedge i_sys_clk) // RL3
    disable iff (!i_rstn) strap_taken |=> $stable(strap))
    else $error("strap changed after reset release");
  AST_MODE_OUT: assert property (@(posedge i_sys_clk) // RL2
    disable iff (!i_rstn) strap_taken |=> o_host_mode == $past(host_mode))
    else $error("mode output differs from strap");
  AST_OE_IN_RESET: assert property (@(posedge i_sys_clk) // RL25
    disable iff (!i_rstn) !strap_taken |=> o_gp_flag_oe == 8'h00)
    else $error("flag driver on before strap frozen");
  AST_HOST_ADDR: assert property (@(posedge i_sys_clk) // RL9
    disable iff (!i_rstn) o_host_mode |-> o_ext_address_bus[13:1] == 13'h0)
    else $error("upper address driven in host mode");
  AST_HOST_DATA: assert property (@(posedge i_sys_clk) // RL10
    disable iff (!i_rstn) o_host_mode |-> o_ext_data_oe[7:0] == 8'h00)
    else $error("low data lanes driven in host mode");
  AST_FULL_ADDR: assert property (@(posedge i_sys_clk) // RL6
    disable iff (!i_rstn) (drive && !host_mode)
    |=> o_ext_address_bus == $past(i_mem_addr))
    else $error("full mode address not passed");
  AST_LEVEL_IRQ: assert property (@(posedge i_sys_clk) // RL16
    disable iff (!i_rstn) (!o_gp_flag_oe[5] && !i_gp_flag[5])
    |=> o_irq_req[1])
    else $error("level request not raised");
  AST_EDGE_IRQ: assert property (@(posedge i_sys_clk) // RL17
    disable iff (!i_rstn) (src_prev[0] && !src[0]) |-> ##2 o_irq_req[0])
    else $error("edge request not latched");
  AST_GRANT_IDLE: assert property (@(posedge i_sys_clk) // RL18
    disable iff (!i_rstn) !o_bus_grant_n
    |-> (o_ext_data_oe == 24'h0 && o_mem_read_n && o_mem_write_n))
    else $error("bus driven while granted");
  AST_HUNG: assert property (@(posedge i_sys_clk) // RL18
    disable iff (!i_rstn) (granted && i_mem_req) |=> !o_bus_grant_hung_n)
    else $error("grant hung not raised");
  AST_ACK: assert property (@(posedge i_sys_clk) // RL12
    disable iff (!i_rstn) hp_busy |=> !o_host_port_ack_n)
    else $error("host access not acknowledged");
  AST_ALT_FLAG_OFF: assert property (@(posedge i_sys_clk) // RL20
    disable iff (!i_rstn) !alt_en |=> !o_serial_alt_flag_out)
    else $error("alt flag out driven while alt use is off");
  AST_IRQ_CFG_TWO_N_EDGE: assert property (@(posedge i_sys_clk) // RL15
    disable iff (!i_rstn)
    (sys_cfg[pin_mux_pkg::CFG_IRQ_CFG_TWO_N_EDGE] && src_prev[3] && !src[3])
    |-> ##2 o_irq_req[3])
    else $error("irq two edge not latched");
  AST_DMA_STEP: assert property (@(posedge i_sys_clk) // RL8
    disable iff (!i_rstn) (hp_wr_fall && !i_host_port_addr_latch)
    |=> o_dma_addr == 16'($past(o_dma_addr) + 16'h0001))
    else $error("host address not stepped after write");
  AST_RDATA_IDLE: assert property (@(posedge i_sys_clk)
    disable iff (!i_rstn) !i_reg_rd |=> o_reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

endmodule // boot_mode_strap_pin_mux

//--- tb/flag_pin_far_end.sv
// far end of the eight flag pins: mode strap buffer, outside logic, pull-ups
// assumes the device drive and enable come straight from the pin mux
`timescale 1ns/1ns
module flag_pin_far_end (
  input wire logic i_rstn,
  input wire logic [2:0] i_strap,
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_dev,
  input wire logic [7:0] i_dev_oe,
  output logic [7:0] o_pin
);
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_dev_oe[b]) begin
        o_pin[b] = i_dev[b];
      end else if (!i_rstn && b < 3) begin
        // strap buffer is enabled by reset only
        o_pin[b] = i_strap[b];
      end else if (i_ext_en[b]) begin
        o_pin[b] = i_ext[b];
      end else begin
        // weak pull-up holds an undriven pin high
        o_pin[b] = 1'h1;
      end
    end
  end
endmodule // flag_pin_far_end

//--- tb/boot_mode_strap_pin_mux_tb.sv
// self-checking bench for the strap capture and pin multiplexer
// assumes the flag pins are resolved by flag_pin_far_end
`timescale 1ns/1ns
module boot_mode_strap_pin_mux_tb;
  logic clk, rstn, reg_wr, reg_rd, mem_req, mem_wr, br_n;
  logic hsel_n, hal, hwr_n, hrd_n, alt_fi, host, dsel_n, psel_n;
  logic iosel_n, bsel_n, csel_n, rd_n, wr_n, bg_n, bgh_n, ack_n, dma_wr;
  logic alt_fo, alt_en, hp_oe, dma_rd;
  logic [15:0] hp_dout;
  logic [23:0] mrd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, had, dma_rdata, dma_addr, dma_wdata;
  logic [7:0] ext, ext_en, pin, gp_out, gp_oe, byte_hi;
  logic [2:0] strap, oflags;
  logic [1:0] space, alt_irq_n;
  logic [13:0] mem_addr, ea;
  logic [23:0] mem_wdata, ed_in, ed, ed_oe;
  logic [5:0] irq;
  int mismatches, total_checks;

  boot_mode_strap_pin_mux DUT (
    .i_sys_clk(clk), .i_rstn(rstn), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_gp_flag(pin), .o_gp_flag(gp_out),
    .o_gp_flag_oe(gp_oe), .o_output_only_flags(oflags),
    .i_serial_alt_irqs_n(alt_irq_n), .i_serial_alt_flag_in(alt_fi),
    .o_serial_alt_flag_out(alt_fo), .o_serial_alt_en(alt_en),
    .o_irq_req(irq),
    .o_host_mode(host), .i_mem_req(mem_req), .i_mem_wr(mem_wr),
    .i_mem_space(space), .i_mem_addr(mem_addr), .i_mem_byte_hi(byte_hi),
    .i_mem_wdata(mem_wdata), .o_mem_rdata(mrd), .o_ext_address_bus(ea),
    .i_ext_data_bus(ed_in), .o_ext_data_bus(ed), .o_ext_data_oe(ed_oe),
    .o_data_space_select_n(dsel_n), .o_program_space_select_n(psel_n),
    .o_io_space_select_n(iosel_n), .o_byte_space_select_n(bsel_n),
    .o_combined_space_select_n(csel_n), .o_mem_read_n(rd_n),
    .o_mem_write_n(wr_n), .i_bus_request_n(br_n), .o_bus_grant_n(bg_n),
    .o_bus_grant_hung_n(bgh_n), .i_host_port_addr_data(had),
    .o_host_port_addr_data(hp_dout), .o_host_port_addr_data_oe(hp_oe),
    .i_host_port_select_n(hsel_n), .i_host_port_addr_latch(hal),
    .i_host_port_write_n(hwr_n), .i_host_port_read_n(hrd_n),
    .o_host_port_ack_n(ack_n), .o_dma_addr(dma_addr),
    .o_dma_wdata(dma_wdata), .o_dma_wr(dma_wr), .o_dma_rd(dma_rd),
    .i_dma_rdata(dma_rdata)
  );

  flag_pin_far_end far (
    .i_rstn(rstn), .i_strap(strap), .i_ext(ext), .i_ext_en(ext_en),
    .i_dev(gp_out), .i_dev_oe(gp_oe), .o_pin(pin)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  // reset with a strap level, then release and wait for the freeze
  task automatic t_mode(input logic [2:0] s);
    logic [15:0] d;
    @(posedge clk);
    rstn <= 1'h0;
    strap <= s;
    tick(4);
    chk(gp_oe, 8'h00);
    rstn <= 1'h1;
    tick(2);
    #1;
    chk(host, s[2]);
    rd_reg(pin_mux_pkg::REG_MODE_STAT, d);
    chk(d[3:0], {s[2], s});
    @(posedge clk);
    ext_en <= 8'h07;
    ext <= {5'h00, ~s};
    tick(4);
    #1;
    chk(host, s[2]);
    @(posedge clk);
    ext_en <= 8'h00;
  endtask

  task automatic t_flags();
    logic [15:0] d;
    wr_reg(pin_mux_pkg::REG_FLAG_DIR, 16'h0007);
    wr_reg(pin_mux_pkg::REG_FLAG_OUT, 16'h0505);
    tick(1);
    #1;
    chk(gp_oe, 8'h07);
    chk(gp_out[2:0], 3'h5);
    chk(oflags, 3'h5);
    rd_reg(pin_mux_pkg::REG_FLAG_IN, d);
    chk(d[2:0], 3'h5);
    wr_reg(pin_mux_pkg::REG_FLAG_DIR, 16'h0000);
  endtask

  task automatic t_irq();
    @(posedge clk);
    ext_en <= 8'hB0;
    ext <= 8'h10;
    tick(3);
    #1;
    chk(irq[3:1], 3'h5);
    @(posedge clk);
    ext <= 8'hA0;
    tick(4);
    #1;
    chk(irq[1:0], 2'h1);
    @(posedge clk);
    ext <= 8'hB0;
    tick(3);
    #1;
    chk(irq[0], 1'h1);
    wr_reg(pin_mux_pkg::REG_IRQ_STAT, 16'h0001);
    tick(1);
    #1;
    chk(irq[0], 1'h0);
    wr_reg(pin_mux_pkg::REG_FLAG_OUT, 16'h0000);
    wr_reg(pin_mux_pkg::REG_FLAG_DIR, 16'h0040);
    tick(2);
    #1;
    chk(irq[2], 1'h1);
    wr_reg(pin_mux_pkg::REG_FLAG_DIR, 16'h0000);
    ext_en <= 8'h00;
  endtask

  // serial pins in interrupt/flag use, irq two and alt one edge triggered
  task automatic t_alt();
    logic [15:0] d;
    wr_reg(pin_mux_pkg::REG_SYS_CFG, 16'h003D);
    wr_reg(pin_mux_pkg::REG_FLAG_OUT, 16'h0800);
    @(posedge clk);
    ext_en <= 8'h80;
    ext <= 8'h00;
    alt_irq_n <= 2'h2;
    alt_fi <= 1'h1;
    tick(3);
    #1;
    chk(irq[5:3], 3'h3);
    chk({alt_fo, alt_en}, 2'h3);
    rd_reg(pin_mux_pkg::REG_FLAG_IN, d);
    chk(d[8], 1'h1);
    @(posedge clk);
    ext <= 8'h80;
    alt_irq_n <= 2'h1;
    tick(3);
    #1;
    chk(irq[5:3], 3'h5);
    wr_reg(pin_mux_pkg::REG_IRQ_STAT, 16'h0028);
    wr_reg(pin_mux_pkg::REG_SYS_CFG, 16'h0030);
    tick(1);
    #1;
    chk(irq[5:3], 3'h0);
    chk({alt_fo, alt_en}, 2'h0);
    @(posedge clk);
    ext_en <= 8'h00;
    alt_irq_n <= 2'h3;
    alt_fi <= 1'h0;
  endtask

  // one access into each space, io as a read, pins checked in the cycle after
  task automatic t_mem(input logic h);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      mem_req <= 1'h1;
      mem_wr <= (s != 2);
      space <= s[1:0];
      mem_addr <= 14'h2AB5;
      mem_wdata <= 24'h9C3E71;
      byte_hi <= 8'hD4;
      @(posedge clk);
      mem_req <= 1'h0;
      #1;
      chk({bsel_n, iosel_n, psel_n, dsel_n}, 4'(~(4'h1 << s)));
      chk(csel_n, s > 1);
      chk({wr_n, rd_n}, (s == 2) ? 2'h2 : 2'h1);
      chk(mrd, h ? 24'h006B2D : 24'h6B2D97);
      if (h) begin
        chk(ea, 14'h0001);
        if (s < 3) chk(ed[23:8], 16'h3E71);
        chk(ed_oe, (s == 2) ? 24'h000000 : 24'hFFFF00);
      end else begin
        chk(ea, 14'h2AB5);
        chk(ed, (s == 3) ? 24'hD43E71 : 24'h9C3E71);
        chk(ed_oe, (s == 2) ? 24'h000000 : 24'hFFFFFF);
      end
    end
  endtask

  task automatic t_grant();
    @(posedge clk);
    br_n <= 1'h0;
    tick(2);
    #1;
    chk(bg_n, 1'h0);
    @(posedge clk);
    mem_req <= 1'h1;
    space <= 2'h0;
    @(posedge clk);
    mem_req <= 1'h0;
    #1;
    chk({bgh_n, dsel_n}, 2'h1);
    @(posedge clk);
    br_n <= 1'h1;
    tick(2);
    #1;
    chk(bg_n, 1'h1);
  endtask

  // the bench plays the host: latch an address, then one write and one read
  task automatic t_host_port(input logic h);
    int pulses;
    logic [15:0] got;
    pulses = 0;
    got = 16'h0000;
    @(posedge clk);
    hsel_n <= 1'h0;
    hal <= 1'h1;
    had <= 16'h0123;
    @(posedge clk);
    hal <= 1'h0;
    #1;
    if (h) chk(dma_addr, 16'h0123);
    @(posedge clk);
    hwr_n <= 1'h0;
    had <= 16'hBEEF;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (dma_wr === 1'h1) begin
        pulses++;
        got = dma_wdata;
      end
    end
    chk(ack_n, !h);
    chk(pulses, h);
    if (h) chk(got, 16'hBEEF);
    @(posedge clk);
    hwr_n <= 1'h1;
    @(posedge clk);
    hrd_n <= 1'h0;
    @(posedge clk);
    #1;
    chk({hp_oe, dma_rd}, {h, h});
    if (h) chk(hp_dout, 16'h5A5A);
    @(posedge clk);
    hrd_n <= 1'h1;
    @(posedge clk);
    hsel_n <= 1'h1;
    #1;
    chk(dma_addr, h ? 16'h0125 : 16'h0000);
  endtask

  initial begin
    {rstn, reg_wr, reg_rd, mem_req, mem_wr, hal, alt_fi} = '0;
    {br_n, hsel_n, hwr_n, hrd_n} = 4'hF;
    {reg_addr, reg_wdata, had, space, mem_addr, mem_wdata} = '0;
    {ext_en, byte_hi, strap} = '0;
    ed_in = 24'h6B2D97;
    ext = 8'hFF;
    alt_irq_n = 2'h3;
    dma_rdata = 16'h5A5A;
    mismatches = 0;
    total_checks = 0;
    t_mode(3'h2);
    t_flags();
    t_irq();
    t_alt();
    t_mem(1'h0);
    t_grant();
    t_host_port(1'h0);
    t_mode(3'h5);
    t_mem(1'h1);
    t_host_port(1'h1);
    test_done();
  end

  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule // boot_mode_strap_pin_mux_tb
